/* core/pcrc_pkg.sv */
// package: register map, field positions, reset values and depths of the crc generator
package pcrc_pkg;
    // register indices on the peripheral port (16-bit registers)
    localparam logic [2:0] PCRC_CONTROL_ONE  = 3'h0;
    localparam logic [2:0] PCRC_CONTROL_TWO  = 3'h1;
    localparam logic [2:0] PCRC_TAPS_LOW     = 3'h2;
    localparam logic [2:0] PCRC_TAPS_HIGH    = 3'h3;
    localparam logic [2:0] PCRC_FIFO_LOW     = 3'h4;
    localparam logic [2:0] PCRC_FIFO_HIGH    = 3'h5;
    localparam logic [2:0] PCRC_RESULT_LOW   = 3'h6;
    localparam logic [2:0] PCRC_RESULT_HIGH  = 3'h7;
    // control_one field positions
    localparam int PCRC_ON_BIT      = 15;
    localparam int PCRC_COUNT_LSB   = 8;
    localparam int PCRC_FULL_BIT    = 7;
    localparam int PCRC_EMPTY_BIT   = 6;
    localparam int PCRC_ISEL_BIT    = 5;
    localparam int PCRC_GO_BIT      = 4;
    localparam int PCRC_LSBF_BIT    = 3;
    // control_two field positions
    localparam int PCRC_WIDTH_LSB   = 8;
    localparam int PCRC_ORDER_LSB   = 0;
    // fifo depth limits
    localparam logic [4:0] PCRC_DEPTH_WIDE   = 5'h04;
    localparam logic [4:0] PCRC_DEPTH_MID    = 5'h08;
    localparam logic [4:0] PCRC_DEPTH_NARROW = 5'h10;
    localparam int         PCRC_FIFO_WORDS   = 16;
    // reset values
    localparam logic [15:0] PCRC_RESET_WORD  = 16'h0000;
    localparam logic [15:0] PCRC_CON1_RESET  = 16'h0040;
endpackage : pcrc_pkg

/* core/pcrc_if.sv */
// interface: peripheral register port between processor side and crc generator
`timescale 1ns/1ps
interface pcrc_if;
    logic [2:0]  addr;       // register index
    logic [15:0] wdata;      // write data
    logic        wr;         // write strobe
    logic        rd;         // read strobe
    logic [15:0] rdata;      // read data, cycle after rd
    logic        irq;        // interrupt pulse
    modport dev (input addr, input wdata, input wr, input rd, output rdata, output irq);
    modport cpu (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface : pcrc_if

/* core/pcrc_engine.sv */
// file: crc generator device end with fifo, shift engine and registers
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// R1 - five-bit field selects polynomial order
// R2 - set tap bit enables xor feedback
// R3 - zero-order term always applied
// R4 - order-N term always included
// R5 - width field is data width minus one
// R6 - fifo depth 4, 8 or 16 by width
// R7 - unused upper bits of byte ignored
// R8 - count increments on top-bit half write
// R9 - software writes low half first
// R10 - start when go set and count nonzero
// R11 - two bits per cycle until empty
// R12 - full at depth, empty at zero
// R13 - module off holds fifo empty
// R14 - software waits a cycle before count read
// R15 - msb first default, lsb when set
// R16 - result stays unreflected
// R17 - isel zero: irq on count 1 to 0
// R18 - isel one: irq on hardware go clear
// R19 - software clearing go gives no irq
// R20 - go clears on completion, result kept
// R21 - software zeroes result before fresh run
// R22 - software preloads then tops up fifo
// R23 - feedback top bit xor data, shift, tap
module pcrc_engine (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    // register port
    pcrc_if.dev       bus
);
    import pcrc_pkg::*;

    // whole module state
    typedef struct packed {
        logic                      on;       // module_on
        logic                      isel;     // irq_cause_sel
        logic                      go;       // calc_go
        logic                      lsbf;     // lsb_first_sel
        logic [4:0]                width;    // input_width_sel
        logic [4:0]                order;    // poly_order_sel
        logic [31:0]               taps;     // poly_taps_high/low
        logic [31:0]               result;   // result_high/low
        logic [31:0]               stage;    // data half staging
        logic [PCRC_FIFO_WORDS-1:0][31:0] mem; // fifo words
        logic [3:0]                wptr;     // fifo write pointer
        logic [3:0]                rptr;     // fifo read pointer
        logic [4:0]                count;    // valid_word_count
        logic [31:0]               buf_w;    // word being shifted
        logic [5:0]                left;     // bits left in buffer
        logic [15:0]               rdata;    // read data
        logic                      irq;      // interrupt pulse
    } pcrc_state_t;

    pcrc_state_t st_q;   // registered state
    pcrc_state_t st_d;   // next state

    // fifo depth for the configured width
    function automatic logic [4:0] pcrc_depth(input logic [4:0] w);
        if (w > 5'h0f) begin
            pcrc_depth = PCRC_DEPTH_WIDE;   // R6
        end else if (w > 5'h07) begin
            pcrc_depth = PCRC_DEPTH_MID;    // R6
        end else begin
            pcrc_depth = PCRC_DEPTH_NARROW; // R6
        end
    endfunction : pcrc_depth

    // mask keeping the low n+1 bits, shared by engine and fifo push
    function automatic logic [31:0] pcrc_mask(input logic [4:0] n);
        pcrc_mask = 32'hffffffff >> (5'h1f - n);
    endfunction : pcrc_mask

    // one engine step: top bit of the order xor data, shift, apply taps
    function automatic logic [31:0] pcrc_step(input logic [31:0] r, input logic [4:0] ord,
                                              input logic [31:0] tp, input logic din);
        logic [31:0] mask;
        logic        fb;
        mask = pcrc_mask(ord);
        fb   = r[ord] ^ din;                                // R23 R1 R4
        pcrc_step = ((r << 1) ^ (fb ? {tp[31:1], 1'b1} : 32'h0)) & mask; // R2 R3 R23
    endfunction : pcrc_step

    // next-state logic
    always_comb begin
        logic [4:0]  depth;
        logic [31:0] r;
        logic        bit_in;
        logic        pushed;
        logic        popped;
        logic        top_half;
        logic [4:0]  ptr;
        st_d     = st_q;
        depth    = pcrc_depth(st_q.width);
        r        = st_q.result;
        bit_in   = 1'b0;
        pushed   = 1'b0;
        popped   = 1'b0;
        top_half = st_q.width > 5'h0f;
        ptr      = '0;
        st_d.irq = 1'b0;
        // shift engine, two bits a cycle
        if (st_q.left != 6'h00) begin
            for (int i = 0; i < 2; i++) begin
                if (6'(i) < st_q.left) begin
                    ptr    = st_q.lsbf ? 5'(st_q.width + 5'h01 - st_q.left[4:0] + 5'(i))
                                       : 5'(st_q.left - 6'h01 - 6'(i)); // R15
                    bit_in = st_q.buf_w[ptr];
                    r      = pcrc_step(r, st_q.order, st_q.taps, bit_in); // R11 R16
                end
            end
            st_d.result = r;
            st_d.left   = (st_q.left > 6'h02) ? st_q.left - 6'h02 : 6'h00;
        end
        // load next word when idle
        if (st_q.go && st_d.left == 6'h00 && st_q.count != 5'h00) begin
            st_d.buf_w = st_q.mem[st_q.rptr];                 // R10
            st_d.left  = 6'(st_q.width) + 6'h01;
            st_d.rptr  = st_q.rptr + 4'h1;
            popped     = 1'b1;
        end
        // completion: go clears by hardware
        if (st_q.go && st_q.left != 6'h00 && st_d.left == 6'h00 && st_q.count == 5'h00) begin
            st_d.go  = 1'b0;                                   // R20
            st_d.irq = st_q.isel;                              // R18
        end
        // register writes
        if (bus.wr) begin
            case (bus.addr)
                PCRC_CONTROL_ONE: begin
                    st_d.on   = bus.wdata[PCRC_ON_BIT];
                    st_d.isel = bus.wdata[PCRC_ISEL_BIT];
                    // a software clear of go never raises irq
                    st_d.go   = bus.wdata[PCRC_GO_BIT];                 // R19
                    st_d.lsbf = bus.wdata[PCRC_LSBF_BIT];
                end
                PCRC_CONTROL_TWO: begin
                    st_d.width = bus.wdata[PCRC_WIDTH_LSB +: 5];    // R5
                    st_d.order = bus.wdata[PCRC_ORDER_LSB +: 5];    // R1
                end
                PCRC_TAPS_LOW:   st_d.taps[15:0]  = bus.wdata;      // R2
                PCRC_TAPS_HIGH:  st_d.taps[31:16] = bus.wdata;      // R2
                PCRC_FIFO_LOW: begin
                    st_d.stage[15:0] = bus.wdata;
                    pushed = !top_half;                             // R8
                end
                PCRC_FIFO_HIGH: begin
                    st_d.stage[31:16] = bus.wdata;
                    pushed = top_half;                              // R8 R9
                end
                PCRC_RESULT_LOW:  st_d.result[15:0]  = bus.wdata;   // R21
                PCRC_RESULT_HIGH: st_d.result[31:16] = bus.wdata;   // R21
                default: ;
            endcase
        end
        // push completed word, masked to width
        if (pushed && st_q.count - 5'(popped) < depth) begin
            st_d.mem[st_q.wptr] = st_d.stage & pcrc_mask(st_q.width); // R7
            st_d.wptr = st_q.wptr + 4'h1;
        end else begin
            pushed = 1'b0;
        end
        st_d.count = st_q.count + 5'(pushed) - 5'(popped);
        if (st_q.isel == 1'b0 && st_q.count == 5'h01 && st_d.count == 5'h00) begin
            st_d.irq = 1'b1;                                   // R17
        end
        // module off: empty fifo, stop
        if (!st_d.on) begin
            st_d.count  = 5'h00;                               // R13
            st_d.wptr   = 4'h0;
            st_d.rptr   = 4'h0;
            st_d.left   = 6'h00;
            st_d.stage  = '0;
            st_d.result = '0;
            st_d.go     = 1'b0;
        end
        // read data for next cycle
        st_d.rdata = PCRC_RESET_WORD;
        if (bus.rd) begin
            case (bus.addr)
                PCRC_CONTROL_ONE: begin
                    st_d.rdata[PCRC_ON_BIT]    = st_q.on;
                    st_d.rdata[PCRC_COUNT_LSB +: 5] = st_q.count;
                    st_d.rdata[PCRC_FULL_BIT]  = st_q.count >= depth;   // R12
                    st_d.rdata[PCRC_EMPTY_BIT] = st_q.count == 5'h00;   // R12
                    st_d.rdata[PCRC_ISEL_BIT]  = st_q.isel;
                    st_d.rdata[PCRC_GO_BIT]    = st_q.go;
                    st_d.rdata[PCRC_LSBF_BIT]  = st_q.lsbf;
                end
                PCRC_CONTROL_TWO: begin
                    st_d.rdata[PCRC_WIDTH_LSB +: 5] = st_q.width;
                    st_d.rdata[PCRC_ORDER_LSB +: 5] = st_q.order;
                end
                PCRC_TAPS_LOW:    st_d.rdata = st_q.taps[15:0];
                PCRC_TAPS_HIGH:   st_d.rdata = st_q.taps[31:16];
                PCRC_RESULT_LOW:  st_d.rdata = st_q.result[15:0];
                PCRC_RESULT_HIGH: st_d.rdata = st_q.result[31:16];
                default:          st_d.rdata = PCRC_RESET_WORD;
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign bus.rdata = st_q.rdata;
    assign bus.irq   = st_q.irq;
endmodule : pcrc_engine

/* core/pcrc_host.sv */
// file: processor-side end, turns simple commands into register port strobes
`timescale 1ns/1ps
module pcrc_host (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    // user command port
    input  wire logic [2:0]  cmd_addr_in,
    input  wire logic [15:0] cmd_wdata_in,
    input  wire logic        cmd_wr_in,
    input  wire logic        cmd_rd_in,
    output logic      [15:0] cmd_rdata_out,
    output logic             cmd_rvalid_out,
    output logic             cmd_irq_out,
    // register port
    pcrc_if.cpu              bus
);
    import pcrc_pkg::*;

    // host state
    typedef struct packed {
        logic [2:0]  addr;    // driven index
        logic [15:0] wdata;   // driven data
        logic        wr;      // write strobe
        logic        rd;      // read strobe
        logic        rwait;   // read returning
        logic [15:0] rdata;   // captured read data
        logic        rvalid;  // read data valid pulse
        logic        irq;     // interrupt seen
    } pcrc_host_t;

    pcrc_host_t h_q;   // registered state
    pcrc_host_t h_d;   // next state

    // command to strobe translation; write wins a clash
    always_comb begin
        h_d        = h_q;
        h_d.wr     = cmd_wr_in;
        h_d.rd     = cmd_rd_in && !cmd_wr_in;
        h_d.addr   = cmd_addr_in;
        h_d.wdata  = cmd_wdata_in;
        h_d.rwait  = h_q.rd;
        h_d.rvalid = h_q.rwait;
        if (h_q.rwait) begin
            h_d.rdata = bus.rdata;
        end
        h_d.irq    = bus.irq;
    end

    // state register
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    // outputs
    assign bus.addr       = h_q.addr;
    assign bus.wdata      = h_q.wdata;
    assign bus.wr         = h_q.wr;
    assign bus.rd         = h_q.rd;
    assign cmd_rdata_out  = h_q.rdata;
    assign cmd_rvalid_out = h_q.rvalid;
    assign cmd_irq_out    = h_q.irq;
endmodule : pcrc_host

/* tb/pcrc_asserts.sv */
// checker: register port rules of the crc generator
`timescale 1ns/1ps
module pcrc_asserts
    import pcrc_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk_in,
    input wire logic        sys_rst_in,
    // register port signals
    input wire logic [2:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        irq
);
    logic       on_q;  // shadow of module_on
    logic [4:0] wf_q;  // shadow of input_width_sel
    logic [4:0] dep;   // fifo depth for that width
    // follow configuration writes
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            on_q <= 1'b0;
            wf_q <= 5'h00;
        end else if (wr && addr == PCRC_CONTROL_ONE) begin
            on_q <= wdata[PCRC_ON_BIT];
        end else if (wr && addr == PCRC_CONTROL_TWO) begin
            wf_q <= wdata[PCRC_WIDTH_LSB +: 5];
        end
    end
    // depth by width
    assign dep = (wf_q > 5'h0f) ? PCRC_DEPTH_WIDE :
                 (wf_q > 5'h07) ? PCRC_DEPTH_MID : PCRC_DEPTH_NARROW;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_irq_one_cycle: assert property (
        irq |=> !irq) else $error("irq longer than one cycle");
    a_off_count: assert property (
        rd && addr == PCRC_CONTROL_ONE && !on_q |=> rdata[PCRC_COUNT_LSB +: 5] == 5'h00)
        else $error("count not zero while off");
    a_off_go: assert property (
        rd && addr == PCRC_CONTROL_ONE && !on_q |=> !rdata[PCRC_GO_BIT])
        else $error("go set while off");
    a_off_result: assert property (
        rd && addr >= PCRC_RESULT_LOW && !on_q |=> rdata == 16'h0000)
        else $error("result not zero while off");
    a_empty_flag: assert property (
        rd && addr == PCRC_CONTROL_ONE |=>
            rdata[PCRC_EMPTY_BIT] == (rdata[PCRC_COUNT_LSB +: 5] == 5'h00))
        else $error("empty flag wrong");
    a_full_flag: assert property (
        rd && addr == PCRC_CONTROL_ONE |=>
            rdata[PCRC_FULL_BIT] == (rdata[PCRC_COUNT_LSB +: 5] >= $past(dep)))
        else $error("full flag wrong");
    a_count_max: assert property (
        rd && addr == PCRC_CONTROL_ONE |=> rdata[PCRC_COUNT_LSB +: 5] <= $past(dep))
        else $error("count above depth");
    a_irq_off_quiet: assert property (
        !on_q && !$past(on_q) && !$past(on_q, 2) |-> !irq)
        else $error("irq while module off");
endmodule : pcrc_asserts

/* tb/tb.sv */
// testbench: host and engine joined, random crc runs against a bench model
`timescale 1ns/1ps
module tb;
    import pcrc_pkg::*;
    logic        clk = 1'b0;    // 125 MHz
    logic        rst = 1'b1;    // active high
    logic [2:0]  c_addr = 3'h0; // command index
    logic [15:0] c_wd = 16'h0;  // command data
    logic        c_wr = 1'b0;   // command write
    logic        c_rd = 1'b0;   // command read
    logic [15:0] c_rdata;       // read result
    logic        c_rv;          // read valid
    logic        c_irq;         // delayed irq
    int err_total = 0, compares = 0, irq_n = 0, cyc = 0;
    pcrc_if bus_if ();
    pcrc_engine i_pcrc_engine (.ref_clk_in(clk), .sys_rst_in(rst), .bus(bus_if.dev));
    pcrc_host i_pcrc_host (.ref_clk_in(clk), .sys_rst_in(rst), .cmd_addr_in(c_addr),
        .cmd_wdata_in(c_wd), .cmd_wr_in(c_wr), .cmd_rd_in(c_rd), .cmd_rdata_out(c_rdata),
        .cmd_rvalid_out(c_rv), .cmd_irq_out(c_irq), .bus(bus_if.cpu));
    pcrc_asserts i_pcrc_asserts (.ref_clk_in(clk), .sys_rst_in(rst), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
        .irq(bus_if.irq));
    always #4 clk = ~clk;
    // count irq pulses, sampled off the edge
    always @(negedge clk) if (c_irq === 1'b1) irq_n++;
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end
    task complete_run;
        $display("counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        c_addr <= a;
        c_wd <= d;
        c_wr <= 1'b1;
        @(posedge clk);
        c_wr <= 1'b0;
    endtask : wr
    task rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        c_addr <= a;
        c_rd <= 1'b1;
        @(posedge clk);
        c_rd <= 1'b0;
        for (int i = 0; i < 8 && c_rv !== 1'b1; i++) @(negedge clk);
        d = c_rdata;
    endtask : rd
    function automatic logic [4:0] dep(input logic [4:0] wf);
        return wf > 5'h0f ? PCRC_DEPTH_WIDE : wf > 5'h07 ? PCRC_DEPTH_MID : PCRC_DEPTH_NARROW;
    endfunction : dep
    // one word through the engine, tap 0 always on, top term implied
    function automatic logic [31:0] crc_word(input logic [31:0] crc, input logic [31:0] tp,
        input logic [4:0] ord, input logic [31:0] d, input logic [4:0] wf, input logic lf);
        logic [31:0] m;
        logic        fb;
        m = 32'hffffffff >> (5'd31 - ord);
        for (int i = 0; i <= int'(wf); i++) begin
            fb = crc[ord] ^ (lf ? d[i] : d[int'(wf) - i]);
            crc = (crc << 1) & m;
            if (fb) crc = crc ^ ((tp | 32'h1) & m);
        end
        return crc;
    endfunction : crc_word
    initial begin
        logic [15:0] v;
        logic [31:0] tp, res, d, exp;
        logic [4:0]  wf, ord;
        logic        lf, is;
        int          n;
        logic [4:0]  corner [5];
        corner = '{5'h1f, 5'h00, 5'h07, 5'h08, 5'h0f};
        void'($urandom(61));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(PCRC_CONTROL_ONE, v);
        chk("con1 reset", 32'(v), 32'(PCRC_CON1_RESET));
        $display("test reset done");
        for (int k = 0; k < 14; k++) begin
            wf = k < 5 ? corner[k] : 5'($urandom_range(31));
            ord = k == 0 ? 5'h1f : 5'($urandom_range(31));
            tp = $urandom;
            lf = k < 4 ? k[0] : 1'($urandom_range(1));
            is = k < 4 ? k[1] : 1'($urandom_range(1));
            n = k < 5 ? int'(dep(wf)) : $urandom_range(int'(dep(wf)), 1);
            wr(PCRC_CONTROL_ONE, {1'b1, 9'h0, is, 1'b0, lf, 3'h0});
            wr(PCRC_CONTROL_TWO, {3'h0, wf, 3'h0, ord});
            wr(PCRC_TAPS_LOW, tp[15:0]);
            wr(PCRC_TAPS_HIGH, tp[31:16]);
            wr(PCRC_RESULT_LOW, 16'h0000);
            wr(PCRC_RESULT_HIGH, 16'h0000);
            rd(PCRC_CONTROL_TWO, v);
            chk("con2", 32'(v), 32'({3'h0, wf, 3'h0, ord}));
            rd(PCRC_TAPS_LOW, v);
            res[15:0] = v;
            rd(PCRC_TAPS_HIGH, v);
            res[31:16] = v;
            chk("taps", res, tp);
            exp = 32'h0;
            // corner cases push one word past full, which is dropped
            for (int j = 0; j < n + (k < 5 ? 1 : 0); j++) begin
                d = $urandom;
                if (wf > 5'h0f) wr(PCRC_FIFO_LOW, d[15:0]);
                wr(wf > 5'h0f ? PCRC_FIFO_HIGH : PCRC_FIFO_LOW, wf > 5'h0f ? d[31:16] : d[15:0]);
                if (j < n) exp = crc_word(exp, tp, ord, d, wf, lf);
            end
            rd(PCRC_CONTROL_ONE, v);
            chk("count", 32'(v[PCRC_COUNT_LSB +: 5]), 32'(n));
            chk("full", 32'(v[PCRC_FULL_BIT]), 32'(n == int'(dep(wf))));
            irq_n = 0;
            wr(PCRC_CONTROL_ONE, {1'b1, 9'h0, is, 1'b1, lf, 3'h0});
            for (int p = 0; p < 100; p++) begin
                rd(PCRC_CONTROL_ONE, v);
                if (v[PCRC_GO_BIT] === 1'b0) break;
            end
            chk("go clear", 32'(v[PCRC_GO_BIT]), 32'h0);
            chk("empty", 32'(v[PCRC_EMPTY_BIT]), 32'h1);
            repeat (4) @(posedge clk);
            rd(PCRC_RESULT_LOW, v);
            res[15:0] = v;
            rd(PCRC_RESULT_HIGH, v);
            res[31:16] = v;
            chk("result", res, exp);
            chk("irq count", 32'(irq_n), 32'h1);
            wr(PCRC_CONTROL_ONE, 16'h0000);
            // pushes while off must not count
            wr(PCRC_FIFO_LOW, 16'hffff);
            wr(PCRC_FIFO_HIGH, 16'hffff);
            rd(PCRC_CONTROL_ONE, v);
            chk("off con1", 32'(v), 32'(PCRC_CON1_RESET));
            rd(PCRC_RESULT_LOW, v);
            chk("off result", 32'(v), 32'h0);
            $display("test crc %0d done", k);
        end
        // software stops a running calculation
        wr(PCRC_CONTROL_ONE, 16'h8020);
        wr(PCRC_CONTROL_TWO, 16'h1f1f);
        for (int j = 0; j < 8; j++) wr(j[0] ? PCRC_FIFO_HIGH : PCRC_FIFO_LOW, 16'($urandom));
        irq_n = 0;
        wr(PCRC_CONTROL_ONE, 16'h8030);
        wr(PCRC_CONTROL_ONE, 16'h8020);
        repeat (100) @(posedge clk);
        chk("no irq on manual clear", 32'(irq_n), 32'h0);
        $display("test manual clear done");
        complete_run();
    end
endmodule : tb
